// File: verilog/vaf_pkg.sv
/*
 * Constants, carrier types and saturating arithmetic helpers for the
 * voice activity detector front end (autocorrelation averaging and Schur).
 * Assumes a single 40 MHz clock domain and an encoder that streams one
 * frame of nine autocorrelation words at a time.
 */
// How it works
// [RL1] Encoder supplies ACF, scaling, lags, signal frame; the code takes only ACF and scaling
// [RL2] Start on ACF arrival; later stages after done
// [RL3] Energy held as 16-bit exponent plus mantissa
// [RL4] Only 16/32-bit integer operations, exponent first
// [RL5] Filter coefficients reset to 24576,-16384,4096,zeros
// [RL6] Coefficient shift resets to seven
// [RL7] Delay lines, pointers, last distance cleared
// [RL8] Threshold, lag, hangover and counters reset values
// [RL9] Normalise ACF0, scale all nine to 16 bits; the code scales only ACF0
// [RL10] Energy exponent 32+2*scale-shift, mantissa sacf0<<3
// [RL11] Averaging shift is ten minus twice scale
// [RL12] Average sums current and three stored values
// [RL13] Delayed average read before overwrite
// [RL14] Pointers advance by nine, wrap at 18/27
// [RL15] Eight reflection coefficients via 16-bit Schur
// [RL16] Weak first term zeroes remaining coefficients
// [RL17] Coefficient is negated-sign quotient, stop at eight
// [RL18] Update first, remaining and mirrored terms rounded
// [RL19] All additions and products saturate
// [RL20] Done pulse when coefficients and energy valid
package vaf_pkg;

    // ------------------------------------------------------------
    // Sizes and counts
    // ------------------------------------------------------------
    localparam int unsigned ACF_N      = 9;
    localparam int unsigned SACF_N     = 27;
    localparam int unsigned SAV_N      = 36;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [15:0] PTR_STEP   = 16'h0009;
    localparam logic [15:0] SACF_WRAP  = 16'h0012; // 18
    localparam logic [15:0] SAV_WRAP   = 16'h001B; // 27
    localparam logic [3:0]  LAST_ORDER = 4'h8;

    // ------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------
    localparam logic [4:0]  SACF_SHR   = 5'h13; // 19
    localparam logic [15:0] EXP_BIAS   = 16'h0020; // 32
    localparam logic [15:0] AVG_SCALE0 = 16'h000A; // 10
    localparam logic [3:0]  MANT_SHL   = 4'h3;

    // ------------------------------------------------------------
    // Values after reset of the persistent detector variables
    // ------------------------------------------------------------
    localparam logic [15:0] RVAD0_RST    = 16'h6000; // 24576
    localparam logic [15:0] RVAD1_RST    = 16'hC000; // -16384
    localparam logic [15:0] RVAD2_RST    = 16'h1000; // 4096
    localparam logic [15:0] NORMRVAD_RST = 16'h0007;
    localparam logic [15:0] THR_EXP_RST  = 16'h0014; // 20
    localparam logic [15:0] THR_MANT_RST = 16'h7A12; // 31250
    localparam logic [15:0] OLDLAG_RST   = 16'h0028; // 40
    localparam logic [15:0] HANG_RST     = 16'hFFFF; // -1

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] exp;
        logic [15:0] mant;
    } vaf_pfloat_t;

    typedef struct packed {
        logic [31:0] acf;
        logic [15:0] scale;
    } vaf_word_t;

    typedef struct packed {
        logic [8:0][15:0] rvad;
        logic [15:0]      normrvad;
        logic [31:0]      last_dm;
        vaf_pfloat_t      thr;
        logic [15:0]      old_lag;
        logic [15:0]      old_lagcount;
        logic [15:0]      vold_lagcount;
        logic [15:0]      adapt_count;
        logic [15:0]      burst_count;
        logic [15:0]      hang_count;
        logic [15:0]      tone;
    } vaf_persist_t;

    // ------------------------------------------------------------
    // Saturating helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] vaf_add16(input logic [15:0] a, input logic [15:0] b);
        logic signed [16:0] s;
        s = $signed({a[15], a}) + $signed({b[15], b});
        if (s > 17'sd32767)       return 16'h7FFF;
        else if (s < -17'sd32768) return 16'h8000;
        else                      return s[15:0];
    endfunction

    function automatic logic [31:0] vaf_add32(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {a[31], a} + {b[31], b};
        if (s[32] != s[31]) return s[32] ? 32'h80000000 : 32'h7FFFFFFF;
        else                return s[31:0];
    endfunction

    // Rounded fractional product
    function automatic logic [15:0] vaf_mult_r(input logic [15:0] a, input logic [15:0] b);
        logic signed [31:0] p;
        logic signed [31:0] r;
        p = $signed(a) * $signed(b);
        r = (p + 32'sd16384) >>> 15;
        if (r > 32'sd32767) return 16'h7FFF;
        else                return r[15:0];
    endfunction

    function automatic logic [15:0] vaf_abs16(input logic [15:0] a);
        if (a == 16'h8000) return 16'h7FFF;
        else if (a[15])    return 16'(-$signed(a));
        else               return a;
    endfunction

    // Left shifts that bring a positive word to bit 30
    function automatic logic [4:0] vaf_norm32(input logic [31:0] x);
        logic [4:0] msb;
        msb = 5'h00;
        for (int b = 0; b < 31; b++) begin
            if (x[b]) msb = 5'(b);
        end
        return 5'h1E - msb;
    endfunction

    // Fractional division, num <= den, both positive
    function automatic logic [15:0] vaf_div(input logic [15:0] num, input logic [15:0] den);
        logic [15:0] q;
        logic [31:0] l_num;
        logic [31:0] l_den;
        q     = 16'h0000;
        l_num = {16'h0000, num};
        l_den = {16'h0000, den};
        if (num == 16'h0000) return 16'h0000;
        if (num == den) return 16'h7FFF;
        for (int i = 0; i < 15; i++) begin
            q     = q << 1;
            l_num = l_num << 1;
            if (l_num >= l_den) begin
                l_num = l_num - l_den;
                q     = q + 16'h0001;
            end
        end
        return q;
    endfunction

endpackage

// File: verilog/vaf_front_end.sv
/*
 * Detector front end: input FIFO, energy renormalisation, averaging delay
 * lines and a 16-bit Schur recursion giving eight reflection coefficients.
 * Assumes the encoder pushes nine autocorrelation words per frame, lag 0
 * first, each carrying the frame's scaling factor; downstream stages wait
 * for the done pulse.
 */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Synchronous FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module vaf_fifo #(
    parameter int unsigned W = 48,
    parameter int unsigned D = 8
) (
    // Clock, reset and enable
    input  wire logic         core_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         en_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(D);

    logic [D-1:0][W-1:0] mem_q;
    logic [AW-1:0]       wr_q;
    logic [AW-1:0]       rd_q;
    logic [AW:0]         cnt_q;
    logic                push;
    logic                pop;

    // Flags from the occupancy count; full is judged at the
    // count's width, as the depth does not fit in a pointer
    assign in_ready_o  = (cnt_q < (AW+1)'(D));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = en_i && in_valid_i && in_ready_o;
    assign pop         = en_i && out_valid_o && out_ready_i;

    // Pointers wrap at the depth, so any depth works
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_q <= '0;
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q        <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vaf_fifo

// ----------------------------------------------------------------
// Front end core
// ----------------------------------------------------------------
module vaf_front_end (
    // Clock, reset, enable
    input  wire logic                  core_clk_i,
    input  wire logic                  arst_n_i,
    input  wire logic                  en_i,
    // Encoder stream
    input  wire logic                  acf_valid_i,
    output logic                       acf_ready_o,
    input  wire vaf_pkg::vaf_word_t    acf_word_i,
    // Results
    output logic                       frame_done_o,
    output logic [8:1][15:0]           refl_coef_o,
    output vaf_pkg::vaf_pfloat_t       input_energy_o,
    output vaf_pkg::vaf_persist_t      persist_o
);
    import vaf_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_AVG   = 3'b011,
        ST_INIT  = 3'b010,
        ST_SCHUR = 3'b110,
        ST_FIN   = 3'b111
    } vaf_state_e;

    typedef struct packed {
        vaf_state_e              st;
        logic [3:0]              idx;
        logic [8:0][31:0]        acf;
        logic [15:0]             scale;
        logic [26:0][31:0]       avg_sacf_dl;
        logic [35:0][31:0]       avg_delay_line;
        logic [15:0]             scaled_acf_ptr;
        logic [15:0]             avg_ptr;
        logic [8:0][31:0]        delayed_avg;
        logic [8:0][15:0]        p;
        logic [8:0][15:0]        k;
        logic [3:0]              n;
        logic [8:1][15:0]        vpar;
        vaf_pfloat_t             energy;
        logic                    done;
        vaf_persist_t            persist;
    } vaf_core_t;

    vaf_core_t  s_q;
    vaf_core_t  s_d;
    vaf_word_t  fifo_word;
    logic       fifo_valid;
    logic       fifo_pop;

    // ------------------------------------------------------------
    // Input FIFO; the core stalls it while averaging or recursing
    // ------------------------------------------------------------
    vaf_fifo #(
        .W ($bits(vaf_word_t)),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .arst_n_i    (arst_n_i),
        .en_i        (en_i),
        .in_valid_i  (acf_valid_i),
        .in_ready_o  (acf_ready_o),
        .in_data_i   (acf_word_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_word)
    );

    // Popping only while loading keeps frames whole
    assign fifo_pop = (s_q.st == ST_IDLE) || (s_q.st == ST_LOAD);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0]         nrm;
        logic [15:0]        sacf0;
        logic [15:0]        shamt;
        logic [31:0]        cur;
        logic [31:0]        av0;
        logic [5:0]         wi;
        logic [15:0]        v;
        logic signed [31:0] sh;
        nrm   = 5'h00;
        sacf0 = 16'h0000;
        shamt = 16'h0000;
        cur   = 32'h0;
        av0   = 32'h0;
        wi    = 6'h00;
        v     = 16'h0000;
        sh    = 32'sh0;
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            // Start as soon as the first autocorrelation word lands
            ST_IDLE, ST_LOAD: begin
                if (fifo_valid) begin // RL2
                    s_d.acf[s_q.idx] = fifo_word.acf;
                    if (s_q.idx == 4'h0) begin
                        s_d.scale = fifo_word.scale;
                        if (fifo_word.acf != 32'h0) begin
                            nrm = vaf_norm32(fifo_word.acf); // RL9
                        end
                        sh    = $signed(fifo_word.acf << nrm) >>> SACF_SHR; // RL9
                        sacf0 = sh[15:0];
                        // Pseudo-float energy, exponent then mantissa
                        s_d.energy.exp  = vaf_add16(vaf_add16(EXP_BIAS,
                                          fifo_word.scale << 1), 16'(-$signed({11'h0, nrm}))); // RL10 RL3 RL19
                        s_d.energy.mant = sacf0 << MANT_SHL; // RL10 RL3 RL4
                    end
                    if (s_q.idx == 4'(ACF_N - 1)) begin
                        s_d.idx = 4'h0;
                        s_d.st  = ST_AVG;
                    end else begin
                        s_d.idx = s_q.idx + 4'h1;
                        s_d.st  = ST_LOAD;
                    end
                end
            end
            // One lag per cycle through both delay lines
            ST_AVG: begin
                shamt = vaf_add16(AVG_SCALE0, 16'(-$signed(s_q.scale << 1))); // RL11
                sh    = $signed(s_q.acf[s_q.idx]) >>> shamt[4:0]; // RL11
                cur   = sh;
                av0   = vaf_add32(s_q.avg_sacf_dl[s_q.idx], cur); // RL12 RL19
                // Other lags never meet this write; offsets need five bits
                av0   = vaf_add32(s_q.avg_sacf_dl[5'(s_q.idx) + 5'(PTR_STEP)], av0); // RL12
                av0   = vaf_add32(s_q.avg_sacf_dl[5'(s_q.idx) + 5'(PTR_STEP << 1)], av0); // RL12
                wi    = 6'(s_q.scaled_acf_ptr) + 6'(s_q.idx);
                s_d.avg_sacf_dl[wi] = cur; // RL12
                wi    = 6'(s_q.avg_ptr) + 6'(s_q.idx);
                s_d.delayed_avg[s_q.idx] = s_q.avg_delay_line[wi]; // RL13
                s_d.avg_delay_line[wi]   = av0; // RL13
                if (s_q.idx == 4'(ACF_N - 1)) begin
                    s_d.scaled_acf_ptr = (s_q.scaled_acf_ptr == SACF_WRAP) ? 16'h0000 :
                                         s_q.scaled_acf_ptr + PTR_STEP; // RL14
                    s_d.avg_ptr        = (s_q.avg_ptr == SAV_WRAP) ? 16'h0000 :
                                         s_q.avg_ptr + PTR_STEP; // RL14
                    s_d.idx = 4'h0;
                    s_d.st  = ST_INIT;
                end else begin
                    s_d.idx = s_q.idx + 4'h1;
                end
            end
            // Seed the recursion from the delayed averages
            ST_INIT: begin
                // A silent delayed frame leaves all coefficients zero
                if (s_q.delayed_avg[0] == 32'h0) begin
                    s_d.vpar = '0;
                    s_d.st   = ST_FIN;
                end else begin
                    nrm = vaf_norm32(s_q.delayed_avg[0]);
                    for (int i = 0; i < 9; i++) begin
                        sh       = $signed(s_q.delayed_avg[i] << nrm) >>> 16;
                        s_d.p[i] = sh[15:0];
                        if (i >= 1 && i <= 7) begin
                            s_d.k[9 - i] = sh[15:0];
                        end
                    end
                    s_d.n  = 4'h1;
                    s_d.st = ST_SCHUR;
                end
            end
            // One order per cycle, 16-bit operators throughout
            ST_SCHUR: begin
                if ($signed(s_q.p[0]) < $signed(vaf_abs16(s_q.p[1]))) begin
                    for (int i = 1; i <= 8; i++) begin
                        if (4'(i) >= s_q.n) s_d.vpar[i] = 16'h0000; // RL16
                    end
                    s_d.st = ST_FIN; // RL16
                end else begin
                    v = vaf_div(vaf_abs16(s_q.p[1]), s_q.p[0]); // RL17 RL15
                    if ($signed(s_q.p[1]) > 0) v = vaf_add16(16'h0000, 16'(-$signed(v))); // RL17
                    s_d.vpar[s_q.n] = v;
                    if (s_q.n == LAST_ORDER) begin
                        s_d.st = ST_FIN; // RL17
                    end else begin
                        s_d.p[0] = vaf_add16(s_q.p[0], vaf_mult_r(s_q.p[1], v)); // RL18 RL19
                        // Seven terms at most remain, so P[m+1] stays in range
                        for (int m = 1; m <= 7; m++) begin
                            if (4'(m) <= LAST_ORDER - s_q.n) begin
                                s_d.p[m]     = vaf_add16(s_q.p[m + 1],
                                               vaf_mult_r(s_q.k[9 - m], v)); // RL18
                                s_d.k[9 - m] = vaf_add16(s_q.k[9 - m],
                                               vaf_mult_r(s_q.p[m + 1], v)); // RL18
                            end
                        end
                        s_d.n = s_q.n + 4'h1;
                    end
                end
            end
            // Results stand; announce the frame
            ST_FIN: begin
                // Registered, so done shows in the following cycle
                s_d.done = 1'b1; // RL20
                s_d.st   = ST_IDLE;
            end
            default: begin
                s_d.st  = ST_IDLE;
                s_d.idx = 4'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register; the enable freezes everything. The
    // persistent variables are held here; later stages own them
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q                       <= '0; // RL7
            s_q.persist.rvad[0]       <= RVAD0_RST; // RL5
            s_q.persist.rvad[1]       <= RVAD1_RST; // RL5
            s_q.persist.rvad[2]       <= RVAD2_RST; // RL5
            s_q.persist.normrvad      <= NORMRVAD_RST; // RL6
            s_q.persist.thr.exp       <= THR_EXP_RST; // RL8
            s_q.persist.thr.mant      <= THR_MANT_RST; // RL8
            s_q.persist.old_lag       <= OLDLAG_RST; // RL8
            s_q.persist.hang_count    <= HANG_RST; // RL8
        end else if (en_i) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from the state register
    // ------------------------------------------------------------
    assign frame_done_o   = s_q.done;
    assign refl_coef_o    = s_q.vpar;
    assign input_energy_o = s_q.energy;
    assign persist_o      = s_q.persist;

endmodule // vaf_front_end

// File: tb/vaf_front_end_properties.sv
/*
 * Port checker for the detector front end.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/1ps
module vaf_front_end_properties
    import vaf_pkg::*;
(
    // Clock, reset, enable
    input wire logic                 core_clk_i,
    input wire logic                 arst_n_i,
    input wire logic                 en_i,
    // Results
    input wire logic                 frame_done_o,
    input wire logic [8:1][15:0]     refl_coef_o,
    input wire vaf_pkg::vaf_pfloat_t input_energy_o,
    input wire vaf_pkg::vaf_persist_t persist_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    // A frame takes nine pops at least, so done can never recur quickly
    sequence s_quiet;
        !frame_done_o [*8];
    endsequence

    a_done_pulse: assert property (frame_done_o |=> s_quiet)
        else $error("done pulse too long or too close");
    a_freeze_hold: assert property (!en_i |=> $stable(refl_coef_o)
        && $stable(input_energy_o) && $stable(frame_done_o))
        else $error("outputs moved while enable low");
    a_mant_norm: assert property (input_energy_o.mant == 16'h0000
        || input_energy_o.mant[15:14] == 2'b01) else $error("mantissa not normalised");
    a_rvad_reset: assert property (persist_o.rvad[0] == 16'h6000
        && persist_o.rvad[1] == 16'hC000 && persist_o.rvad[2] == 16'h1000
        && persist_o.rvad[8:3] == '0) else $error("filter coefficients wrong");
    a_norm_shift: assert property (persist_o.normrvad == 16'h0007)
        else $error("coefficient shift wrong");
    a_dist_clear: assert property (persist_o.last_dm == 32'h0000_0000)
        else $error("last distance not clear");
    a_thr_reset: assert property (persist_o.thr == {16'h0014, 16'h7A12}
        && persist_o.old_lag == 16'h0028 && persist_o.hang_count == 16'hFFFF)
        else $error("threshold, lag or hangover wrong");
    a_count_clear: assert property ({persist_o.old_lagcount, persist_o.vold_lagcount,
        persist_o.adapt_count, persist_o.burst_count, persist_o.tone} == '0)
        else $error("counters not clear");
endmodule // vaf_front_end_properties

bind vaf_front_end vaf_front_end_properties vaf_front_end_properties_i (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .en_i(en_i),
    .frame_done_o(frame_done_o), .refl_coef_o(refl_coef_o),
    .input_energy_o(input_energy_o), .persist_o(persist_o));

// File: tb/vaf_enc_model.sv
/*
 * Encoder model: streams nine autocorrelation words per frame.
 * Assumes start is raised for one cycle only while busy is low.
 */
`timescale 1ns/1ps
module vaf_enc_model
    import vaf_pkg::*;
(
    // Clock and control from the bench
    input  wire logic             core_clk_i,
    input  wire logic             en_i,
    input  wire logic             start_i,
    input  wire logic [8:0][31:0] words_i,
    input  wire logic [15:0]      scale_i,
    input  wire logic [3:0]       gap_i,
    // Stream to the front end
    input  wire logic             acf_ready_i,
    output logic                  acf_valid_o,
    output vaf_pkg::vaf_word_t    acf_word_o,
    output logic                  busy_o
);
    // Words change after falling edges and stand until taken
    initial begin
        acf_valid_o = 1'b0;
        acf_word_o  = '1;
        busy_o      = 1'b0;
        forever begin
            @(posedge core_clk_i);
            if (start_i) begin
                busy_o = 1'b1;
                @(negedge core_clk_i);
                for (int k = 0; k < 9; k++) begin
                    acf_word_o  = {words_i[k], scale_i};
                    acf_valid_o = 1'b1;
                    do @(posedge core_clk_i); while (!(acf_ready_i && en_i));
                    @(negedge core_clk_i);
                    // Released word is inverted so stale data cannot pass
                    if (k == 8 || gap_i != 4'h0) begin
                        acf_valid_o = 1'b0;
                        acf_word_o  = ~acf_word_o;
                        repeat (gap_i) @(negedge core_clk_i);
                    end
                end
                @(posedge core_clk_i);
                busy_o = 1'b0;
            end
        end
    end
endmodule // vaf_enc_model

// File: tb/test_vad_acf_averaging_front_end.sv
/*
 * Self-checking bench for the detector front end with an encoder model.
 * Assumes the 40 MHz clock and results captured on each done pulse.
 */
`timescale 1ns/1ps
module test_vad_acf_averaging_front_end;
    import vaf_pkg::*;
    logic                 core_clk_i, arst_n_i = 1'b0, en_i = 1'b1, start = 1'b0;
    logic [8:0][31:0]     words = '0;
    logic [15:0]          scale = '0;
    logic [3:0]           gap = '0;
    logic                 acf_valid, acf_ready, frame_done, busy, full_seen = 1'b0;
    vaf_word_t            acf_word;
    logic [8:1][15:0]     refl_coef;
    vaf_pfloat_t          energy;
    vaf_persist_t         persist;
    logic [8:1][15:0]     coef_q[$];
    vaf_pfloat_t          nrg_q[$];
    int                   done_cnt = 0, cycles = 0, total_checks = 0, miscompares = 0;

    vaf_enc_model vaf_enc_model_i (.core_clk_i(core_clk_i), .en_i(en_i), .start_i(start),
        .words_i(words), .scale_i(scale), .gap_i(gap), .acf_ready_i(acf_ready),
        .acf_valid_o(acf_valid), .acf_word_o(acf_word), .busy_o(busy));
    vaf_front_end vaf_front_end_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .en_i(en_i), .acf_valid_i(acf_valid), .acf_ready_o(acf_ready),
        .acf_word_i(acf_word), .frame_done_o(frame_done), .refl_coef_o(refl_coef),
        .input_energy_o(energy), .persist_o(persist));

    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    // Capture results on done; a hang is cut short by the cycle ceiling
    always @(posedge core_clk_i) begin
        cycles++;
        if (frame_done === 1'b1) begin
            done_cnt++;
            coef_q.push_back(refl_coef);
            nrg_q.push_back(energy);
        end
        if (acf_valid && acf_ready === 1'b0) full_seen = 1'b1;
        if (cycles == 6000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Only lags 0 and 1 carry data; the rest of the frame is zero
    task automatic send(input logic [31:0] a0, input logic [31:0] a1,
                        input logic [15:0] sc, input logic [3:0] g);
        int n;
        n = 0;
        while (busy && n < 500) begin
            @(negedge core_clk_i);
            n++;
        end
        words    = '0;
        words[0] = a0;
        words[1] = a1;
        scale    = sc;
        gap      = g;
        start    = 1'b1;
        @(negedge core_clk_i);
        start    = 1'b0;
    endtask

    task automatic wait_done(input int n);
        int c;
        c = 0;
        while (done_cnt < n && c < 400) begin
            @(negedge core_clk_i);
            c++;
        end
        check("done count", 32'(n), 32'(done_cnt));
    endtask

    task automatic t_reset;
        vaf_persist_t p;
        p = '0;
        p.rvad[0] = 16'h6000;
        p.rvad[1] = 16'hC000;
        p.rvad[2] = 16'h1000;
        p.normrvad = 16'h0007;
        p.thr = {16'h0014, 16'h7A12};
        p.old_lag = 16'h0028;
        p.hang_count = 16'hFFFF;
        check("ready", 32'h1, 32'(acf_ready));
        check("coefs", 32'h0, 32'(|refl_coef));
        check("energy", 32'h0, energy);
        check("persist", 32'h1, 32'(persist === p));
    endtask

    // Four frames: delayed averages still zero, energy per frame, FIFO fills
    task automatic t_frames;
        logic [31:0] e_tab[4];
        e_tab = '{32'h002A4000, 32'h00284000, 32'h001248D0, 32'h00247FF8};
        send(32'h40000000, 32'h20000000, 16'h0005, 4'h2);
        repeat (3) @(negedge core_clk_i);
        en_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        en_i = 1'b1;
        wait_done(1);
        send(32'h10000000, 32'h3FFFFFFF, 16'h0005, 4'h0);
        wait_done(2);
        send(32'h00012345, 32'h0, 16'h0000, 4'h0);
        send(32'h7FFFFFFF, 32'h0, 16'h0002, 4'h0);
        wait_done(4);
        check("fifo full seen", 32'h1, 32'(full_seen));
        for (int i = 0; i < 4; i++) begin
            check("energy", e_tab[i], nrg_q[i]);
            check("coef early", 32'h0, 32'(|coef_q[i]));
        end
    endtask

    // Frame five sees frame one's average, frame six frame two's weak one
    task automatic t_schur;
        send(32'h0, 32'h0, 16'h0005, 4'h1);
        wait_done(5);
        send(32'h0, 32'h0, 16'h0005, 4'h0);
        wait_done(6);
        check("zero mant", 32'h0, 32'(nrg_q[4].mant));
        check("coef 1", 32'h0000C000, 32'(coef_q[4][1]));
        check("coef 2", 32'h00002AAA, 32'(coef_q[4][2]));
        check("coef weak", 32'h0, 32'(|coef_q[5]));
    endtask

    initial begin
        repeat (4) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        t_reset();
        t_frames();
        t_schur();
        arst_n_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        arst_n_i = 1'b1;
        t_reset();
        close_out();
    end
endmodule // test_vad_acf_averaging_front_end
